// ===== hdl/fep_core.sv
// fast ethernet phy digital core: 100 and 10 mb/s coding, jabber, mode resolution
module fep_core #(
  parameter int BIT_CYC     = fep_pkg::BIT100_CYC,
  parameter int TEN_BIT_CYC = fep_pkg::BIT10_CYC,
  parameter int JAB_CYC     = fep_pkg::JAB_CYC,
  parameter int UNJAB_CYC   = fep_pkg::UNJAB_CYC
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // mac transmit
  input  wire logic       mac_tx_en,
  input  wire logic [3:0] mac_txd,
  output logic            tx_nib_stb,
  // line side
  output logic [1:0]      mlt3_level,
  output logic            ten_tx_data,
  output logic            ten_tx_en,
  input  wire logic       line_rx,
  input  wire logic       squelch_ok,
  // mac receive
  output logic            rx_nib_stb,
  output logic            rx_dv,
  output logic [3:0]      rxd,
  output logic            rx_er,
  output logic            crs,
  output logic            col,
  // mode control
  input  wire logic       autoneg_strap_pin,
  input  wire logic       sw_ctl_wr,
  input  wire logic       sw_an_en,
  input  wire logic       sw_speed100,
  input  wire logic       sw_full_duplex,
  input  wire logic [3:0] local_abil,
  input  wire logic [3:0] partner_abil,
  input  wire logic       partner_valid,
  input  wire logic       pd_100_seen,
  input  wire logic       pd_10_seen,
  // resolved mode
  output logic            an_enabled,
  output logic            speed100,
  output logic            full_duplex,
  output logic            mode_ok
);
  if (BIT_CYC < 4 || TEN_BIT_CYC < 8 || TEN_BIT_CYC > 255 || UNJAB_CYC >= 2**25 || JAB_CYC >= 2**25) begin : g_chk
    $error("fep_core: parameter out of range");
  end

  typedef struct packed {
    logic            strap_s1, strap_s2, rx_s1, rx_s2, sq_s1, sq_s2;
    logic [1:0]      strap_age;
    logic            an_en, sw_speed, sw_dup, speed100, full_dup, mode_ok;
    logic [7:0]      tx_div;
    logic [2:0]      tx_bc;
    logic [4:0]      tx_sh;
    fep_pkg::fep_tx_t tx_st;
    logic [10:0]     scr;
    logic            nrzi;
    logic [1:0]      mlt_idx, mlt3;
    logic            tx_nib_stb, ten_active, ten_data, ten_en, tx_en_d;
    logic            jab;
    logic [24:0]     jab_cnt;
    logic [7:0]      sqe_cnt;
    logic            col;
    logic            rx_prev, rx_nrzi;
    logic [7:0]      rx_ph;
    logic [10:0]     dsc;
    logic            dsc_lock;
    logic [5:0]      dsc_cnt;
    logic [9:0]      rx_sh;
    logic            rx_al;
    logic [2:0]      rx_bc;
    logic [3:0]      rxd;
    logic            rx_dv, rx_er, crs, rx_nib_stb;
  } fep_st_t;

  fep_st_t s;
  fep_st_t n;
  logic [7:0] lim;
  logic       tick, cur, key, scr_bit, edge_s, samp, nrz, dkey, plain, bit10, dec_ok;
  logic [3:0] common, dec_nib;
  logic [4:0] sym;

  // next-state logic for the whole core
  always_comb begin
    n = s;
    dec_ok = 1'b0;
    dec_nib = 4'h0;
    sym = 5'h0;
    common = local_abil & partner_abil;
    // pin synchronisers
    n.strap_s1 = autoneg_strap_pin;
    n.strap_s2 = s.strap_s1;
    n.rx_s1 = line_rx;
    n.rx_s2 = s.rx_s1;
    n.sq_s1 = squelch_ok;
    n.sq_s2 = s.sq_s1;
    lim = s.speed100 ? BIT_CYC[7:0] : TEN_BIT_CYC[7:0];

    // strap capture once settled, then software writes
    if (s.strap_age != 2'h3) begin
      n.strap_age = s.strap_age + 2'h1;
      if (s.strap_age == 2'h2) n.an_en = s.strap_s2;
    end
    if (sw_ctl_wr) begin
      n.an_en = sw_an_en;
      n.sw_speed = sw_speed100;
      n.sw_dup = sw_full_duplex;
    end

    // mode resolution
    if (!s.an_en) begin
      n.speed100 = s.sw_speed;
      n.full_dup = s.sw_dup;
      n.mode_ok = 1'b1;
    end else if (partner_valid) begin
      n.mode_ok = |common;
      n.speed100 = common[fep_pkg::AB_100F] | common[fep_pkg::AB_100H];
      n.full_dup = common[fep_pkg::AB_100F] | (~common[fep_pkg::AB_100H] & common[fep_pkg::AB_10F]);
    end else if (pd_100_seen || pd_10_seen) begin
      n.mode_ok = 1'b1;
      n.speed100 = pd_100_seen;
      n.full_dup = 1'b0;
    end

    // transmit bit timing from the local reference
    tick = s.tx_div >= lim - 8'h1;
    n.tx_div = tick ? 8'h0 : s.tx_div + 8'h1;
    cur = s.speed100 ? s.tx_sh[4] : s.tx_sh[0];
    key = s.scr[10] ^ s.scr[8];
    scr_bit = cur ^ key;
    n.tx_nib_stb = 1'b0;
    if (tick) begin
      n.tx_nib_stb = s.tx_bc == (s.speed100 ? 3'h4 : 3'h3);
      n.tx_bc = n.tx_nib_stb ? 3'h0 : s.tx_bc + 3'h1;
      n.tx_sh = s.speed100 ? {s.tx_sh[3:0], 1'b0} : {1'b0, s.tx_sh[4:1]};
      if (s.speed100) begin
        n.scr = {s.scr[9:0], key};
        n.nrzi = s.nrzi ^ scr_bit;
        if (n.nrzi != s.nrzi) n.mlt_idx = s.mlt_idx + 2'h1;
        n.mlt3 = n.mlt_idx == 2'h1 ? 2'h1 : (n.mlt_idx == 2'h3 ? 2'h3 : 2'h0);
      end else begin
        n.ten_data = cur & s.ten_active;
      end
    end

    // symbol load at each nibble boundary
    if (s.tx_nib_stb) begin
      n.tx_en_d = mac_tx_en;
      if (s.speed100) begin
        n.ten_active = 1'b0;
        unique case (s.tx_st)
          fep_pkg::TX_IDLE: begin
            n.tx_sh = mac_tx_en ? fep_pkg::SYM_J : fep_pkg::SYM_I;
            if (mac_tx_en) n.tx_st = fep_pkg::TX_K;
          end
          fep_pkg::TX_K: begin
            n.tx_sh = fep_pkg::SYM_K;
            n.tx_st = fep_pkg::TX_DATA;
          end
          fep_pkg::TX_DATA: begin
            n.tx_sh = mac_tx_en ? fep_pkg::ENC[mac_txd] : fep_pkg::SYM_T;
            if (!mac_tx_en) n.tx_st = fep_pkg::TX_R;
          end
          fep_pkg::TX_R: begin
            n.tx_sh = fep_pkg::SYM_R;
            n.tx_st = fep_pkg::TX_IDLE;
          end
          default: n.tx_st = fep_pkg::TX_IDLE;
        endcase
      end else begin
        n.tx_st = fep_pkg::TX_IDLE;
        n.tx_sh = {1'b0, mac_txd};
        n.ten_active = mac_tx_en;
        if (s.tx_en_d && !mac_tx_en && !s.jab) n.sqe_cnt = 8'(fep_pkg::SQE_DLY_CYC + fep_pkg::SQE_LEN_CYC);
      end
    end
    if (s.sqe_cnt != 8'h0) n.sqe_cnt = s.sqe_cnt - 8'h1;

    // jabber watchdog on the 10 mb/s transmitter
    if (s.speed100) begin
      n.jab = 1'b0;
      n.jab_cnt = 25'h0;
    end else if (!s.jab) begin
      n.jab_cnt = mac_tx_en ? s.jab_cnt + 25'h1 : 25'h0;
      if (mac_tx_en && s.jab_cnt == 25'(JAB_CYC)) begin
        n.jab = 1'b1;
        n.jab_cnt = 25'h0;
      end
    end else begin
      n.jab_cnt = mac_tx_en ? 25'h0 : s.jab_cnt + 25'h1;
      if (!mac_tx_en && s.jab_cnt == 25'(UNJAB_CYC)) begin
        n.jab = 1'b0;
        n.jab_cnt = 25'h0;
      end
    end
    n.ten_en = s.ten_active & ~n.jab & ~s.speed100;
    n.col = s.jab | (s.sqe_cnt != 8'h0 && s.sqe_cnt <= 8'(fep_pkg::SQE_LEN_CYC))
          | (~s.full_dup & mac_tx_en & s.crs);

    // receive bit recovery from line edges
    edge_s = s.rx_s2 ^ s.rx_prev;
    n.rx_prev = s.rx_s2;
    if (s.speed100 && edge_s) n.rx_ph = 8'h0;
    else if (!s.speed100 && edge_s && s.rx_ph > (lim >> 2) && s.rx_ph < lim - (lim >> 2)) n.rx_ph = lim >> 1;
    else n.rx_ph = s.rx_ph >= lim - 8'h1 ? 8'h0 : s.rx_ph + 8'h1;
    samp = s.speed100 ? s.rx_ph == (lim >> 1) : s.rx_ph == (lim >> 2) && s.sq_s2;
    nrz = s.rx_s2 ^ s.rx_nrzi;
    dkey = s.dsc[10] ^ s.dsc[8];
    plain = nrz ^ dkey;
    bit10 = ~s.rx_s2;
    n.rx_nib_stb = 1'b0;
    if (s.speed100 && samp) begin
      n.rx_nrzi = s.rx_s2;
      if (!s.dsc_lock) begin
        n.dsc = {s.dsc[9:0], ~nrz};
        n.dsc_cnt = (~nrz == dkey) ? s.dsc_cnt + 6'h1 : 6'h0;
        n.dsc_lock = s.dsc_cnt == 6'(fep_pkg::DSC_LOCK);
      end else begin
        n.dsc = {s.dsc[9:0], dkey};
      end
      n.rx_sh = {s.rx_sh[8:0], plain};
      if (!s.rx_al) begin
        if (s.dsc_lock && n.rx_sh == {fep_pkg::SYM_J, fep_pkg::SYM_K}) begin
          n.rx_al = 1'b1;
          n.rx_bc = 3'h0;
          n.crs = 1'b1;
          n.rx_dv = 1'b1;
          n.rxd = fep_pkg::NIB_PRE;
          n.rx_er = 1'b0;
          n.rx_nib_stb = 1'b1;
        end
      end else if (s.rx_bc != 3'h4) begin
        n.rx_bc = s.rx_bc + 3'h1;
      end else begin
        n.rx_bc = 3'h0;
        sym = n.rx_sh[4:0];
        for (int i = 0; i < 16; i++) begin
          if (fep_pkg::ENC[i] == sym) begin
            dec_ok = 1'b1;
            dec_nib = 4'(i);
          end
        end
        if (sym == fep_pkg::SYM_T || sym == fep_pkg::SYM_I) begin
          n.rx_al = 1'b0;
          n.rx_dv = 1'b0;
          n.crs = 1'b0;
        end else begin
          n.rxd = dec_nib;
          n.rx_er = ~dec_ok;
          n.rx_nib_stb = 1'b1;
        end
      end
    end else if (!s.speed100) begin
      if (!s.sq_s2) begin
        n.crs = 1'b0;
        n.rx_dv = 1'b0;
      end else if (samp) begin
        n.crs = 1'b1;
        n.rx_sh = {s.rx_sh[8:0], bit10};
        if (!s.rx_dv) begin
          n.rx_dv = s.rx_sh[0] & bit10;
          n.rx_bc = 3'h0;
        end else if (s.rx_bc != 3'h3) begin
          n.rx_bc = s.rx_bc + 3'h1;
        end else begin
          n.rx_bc = 3'h0;
          n.rxd = {bit10, s.rx_sh[0], s.rx_sh[1], s.rx_sh[2]};
          n.rx_er = 1'b0;
          n.rx_nib_stb = 1'b1;
        end
      end
    end
    // receive clock keeps ticking from the reference while no frame is present
    if (!s.rx_dv && !n.rx_dv) n.rx_nib_stb = n.tx_nib_stb;
  end

  // state register
  always_ff @(posedge clock) begin
    if (rst) begin
      s <= '0;
      s.an_en <= fep_pkg::DEF_AN_EN;
      s.sw_speed <= fep_pkg::DEF_SPEED100;
      s.sw_dup <= fep_pkg::DEF_FULL;
      s.speed100 <= fep_pkg::DEF_SPEED100;
      s.full_dup <= fep_pkg::DEF_FULL;
      s.tx_st <= fep_pkg::TX_IDLE;
      s.tx_sh <= fep_pkg::SYM_I;
      s.scr <= 11'h7ff;
    end else begin
      s <= n;
    end
  end

  // outputs
  assign tx_nib_stb  = s.tx_nib_stb;
  assign mlt3_level  = s.mlt3;
  assign ten_tx_data = s.ten_data;
  assign ten_tx_en   = s.ten_en;
  assign rx_nib_stb  = s.rx_nib_stb;
  assign rx_dv       = s.rx_dv;
  assign rxd         = s.rxd;
  assign rx_er       = s.rx_er;
  assign crs         = s.crs;
  assign col         = s.col;
  assign an_enabled  = s.an_en;
  assign speed100    = s.speed100;
  assign full_duplex = s.full_dup;
  assign mode_ok     = s.mode_ok;

  // checks
  property p_no_scr_10;
    @(posedge clock) disable iff (rst) !s.speed100 |=> $stable(s.scr);
  endproperty
  a_no_scr_10: assert property (p_no_scr_10) else $error("scrambler moved at 10 mb/s");
  property p_nrzi;
    @(posedge clock) disable iff (rst) (s.speed100 && tick && scr_bit) |=> s.nrzi != $past(s.nrzi);
  endproperty
  a_nrzi: assert property (p_nrzi) else $error("nrzi missed a transition");
  property p_jab_col;
    @(posedge clock) disable iff (rst) s.jab |-> ##1 col;
  endproperty
  a_jab_col: assert property (p_jab_col) else $error("collision low in jabber");
  property p_unjab;
    @(posedge clock) disable iff (rst) $fell(s.jab) && !s.speed100 |-> !$past(mac_tx_en, 2);
  endproperty
  a_unjab: assert property (p_unjab) else $error("jabber left while enable high");
  property p_sqe;
    @(posedge clock) disable iff (rst)
      (s.tx_nib_stb && !s.speed100 && s.tx_en_d && !mac_tx_en && !s.jab) |-> ##[100:250] col;
  endproperty
  a_sqe: assert property (p_sqe) else $error("no sqe pulse after frame");
  property p_sw_an;
    @(posedge clock) disable iff (rst) sw_ctl_wr |=> an_enabled == $past(sw_an_en);
  endproperty
  a_sw_an: assert property (p_sw_an) else $error("enable write lost");
  property p_forced;
    @(posedge clock) disable iff (rst) !s.an_en |=> speed100 == $past(s.sw_speed) && full_duplex == $past(s.sw_dup);
  endproperty
  a_forced: assert property (p_forced) else $error("forced mode not applied");
  property p_best;
    @(posedge clock) disable iff (rst) (s.an_en && partner_valid && common[3]) |=> speed100 && full_duplex;
  endproperty
  a_best: assert property (p_best) else $error("best common mode not chosen");
  property p_pd;
    @(posedge clock) disable iff (rst) (s.an_en && !partner_valid && pd_100_seen) |=> speed100 && !full_duplex;
  endproperty
  a_pd: assert property (p_pd) else $error("parallel detect ignored");
endmodule : fep_core

// ===== hdl/fep_pkg.sv
// constants, types and symbol tables of the fast ethernet phy core
// What this block does
// - transmit order: 4b5b encode, serialize, scramble, nrzi, mlt3
// - each mac nibble becomes a serial bit stream before line coding
// - scrambled stream goes to nrzi, then drives the line as mlt3
// - receive bit clock is recovered from edges of the incoming nrzi signal
// - received nrz goes through descrambler, 4b5b decoder, then to nibbles
// - scrambling and descrambling only happen at 100 mb/s
// - 10 mb/s receive splits manchester into clock and data once squelch passes
// - 10 mb/s receive clock keeps running between frames
// - 10 mb/s sends a short sqe pulse on collision after each frame that ends outside jabber
// - 10 mb/s transmit enable high over 20 ms disables transmitter, collision high
// - transmit enable low over 250 ms re-enables transmitter, collision low
// - all timing derives from the single reference clock input
// - both partners advertise, compare, and use the best common mode
// - mode ranking: 100 full, 100 half, 10 full, 10 half
// - partner without negotiation: speed comes from signalling seen at the receiver, half duplex
// - negotiation enabled by strap pin or control enable bit, strap default on
// - negotiation starts from the strap pin after reset, software may change it later
// - negotiation off: speed and duplex come from control bits
package fep_pkg;
  localparam int CLK_MHZ      = 100;
  localparam int JABBER_MS    = 20;
  localparam int UNJAB_MS     = 250;
  localparam int SQE_DLY_NS   = 1000;
  localparam int SQE_LEN_NS   = 1000;
  localparam int JAB_CYC      = JABBER_MS * 1000 * CLK_MHZ;
  localparam int UNJAB_CYC    = UNJAB_MS * 1000 * CLK_MHZ;
  localparam int SQE_DLY_CYC  = SQE_DLY_NS * CLK_MHZ / 1000;
  localparam int SQE_LEN_CYC  = SQE_LEN_NS * CLK_MHZ / 1000;
  localparam int BIT100_CYC   = 4;
  localparam int BIT10_CYC    = 10;
  localparam int DSC_LOCK     = 30;
  localparam logic DEF_SPEED100 = 1'b1;
  localparam logic DEF_FULL     = 1'b0;
  localparam logic DEF_AN_EN    = 1'b1;
  // ability bit positions
  localparam int AB_100F = 3;
  localparam int AB_100H = 2;
  localparam int AB_10F  = 1;
  // line symbols
  localparam logic [4:0] SYM_I = 5'h1f;
  localparam logic [4:0] SYM_J = 5'h18;
  localparam logic [4:0] SYM_K = 5'h11;
  localparam logic [4:0] SYM_T = 5'h0d;
  localparam logic [4:0] SYM_R = 5'h07;
  localparam logic [3:0] NIB_PRE = 4'h5;
  localparam logic [4:0] ENC [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
                                      5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001,
    TX_K    = 4'b0010,
    TX_DATA = 4'b0100,
    TX_R    = 4'b1000
  } fep_tx_t;
endpackage : fep_pkg

// ===== tb/fep_core_test.sv
// self-checking bench of the phy core: mode resolution, 100 mb/s receive, sqe, jabber
module fep_core_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 0, rst = 1, mac_tx_en = 0, sw_ctl_wr = 0, sw_an_en = 1, sw_speed100 = 1;
  logic sw_full_duplex = 0, partner_valid = 0, pd_100_seen = 0, pd_10_seen = 0;
  logic squelch_ok = 0, autoneg_strap_pin = 1;
  logic [3:0] mac_txd = 4'h0, partner_abil = 4'h0, local_abil = 4'hf, rxd;
  logic [1:0] mlt3_level;
  logic tx_nib_stb, ten_tx_data, ten_tx_en, rx_nib_stb, rx_dv, rx_er, crs, col;
  logic an_enabled, speed100, full_duplex, mode_ok;
  wire  line_rx;
  int   errors = 0, num_checks = 0;
  logic [3:0] rq[$];

  // device under test with short jabber counts
  fep_core #(.JAB_CYC(400), .UNJAB_CYC(200)) fep_core_i (
    .clock, .rst, .mac_tx_en, .mac_txd, .tx_nib_stb, .mlt3_level, .ten_tx_data, .ten_tx_en,
    .line_rx, .squelch_ok, .rx_nib_stb, .rx_dv, .rxd, .rx_er, .crs, .col,
    .autoneg_strap_pin, .sw_ctl_wr, .sw_an_en, .sw_speed100, .sw_full_duplex, .local_abil,
    .partner_abil, .partner_valid, .pd_100_seen, .pd_10_seen, .an_enabled, .speed100,
    .full_duplex, .mode_ok);
  fep_lp fep_lp_i (.line_rx(line_rx));

  // clock
  initial begin
    forever #5 clock = ~clock;
  end
  // collect received nibbles
  always @(posedge clock) begin
    if (rx_nib_stb && rx_dv) rq.push_back(rxd);
  end

  task check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : check
  task close_out;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  task cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc
  // software control write, then settle to a falling edge
  task ctl(input logic a, input logic s, input logic f);
    @(posedge clock);
    sw_an_en <= a;
    sw_speed100 <= s;
    sw_full_duplex <= f;
    sw_ctl_wr <= 1'b1;
    @(posedge clock);
    sw_ctl_wr <= 1'b0;
    cyc(3);
    @(negedge clock);
  endtask : ctl

  task t_reset;
    @(negedge clock);
    check({an_enabled, speed100, full_duplex, mode_ok}, 4'b1100);
    $display("test reset done");
  endtask : t_reset
  task t_modes;
    logic [3:0] ab [4];
    logic [1:0] ex [4];
    ab = '{4'hf, 4'h7, 4'h3, 4'h1};
    ex = '{2'h3, 2'h2, 2'h1, 2'h0};
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      partner_abil <= ab[i];
      partner_valid <= 1'b1;
      cyc(3);
      @(negedge clock);
      check({2'h0, speed100, full_duplex}, {2'h0, ex[i]});
      check({3'h0, mode_ok}, 4'h1);
    end
    $display("test modes done");
  endtask : t_modes
  task t_pd;
    @(posedge clock);
    partner_valid <= 1'b0;
    pd_10_seen <= 1'b1;
    cyc(3);
    @(negedge clock);
    check({3'h0, speed100}, 4'h0);
    @(posedge clock);
    pd_10_seen <= 1'b0;
    pd_100_seen <= 1'b1;
    cyc(3);
    @(negedge clock);
    check({3'h0, speed100}, 4'h1);
    $display("test detect done");
  endtask : t_pd
  task t_rx;
    logic [2:0] lv;
    logic       seen;
    lv = 3'h0;
    seen = 1'b0;
    // idle line levels while the descrambler locks: only +1, 0 and -1 are legal
    for (int k = 0; k < 1500; k++) begin
      @(negedge clock);
      if (mlt3_level == 2'h1) lv[0] = 1'b1;
      if (mlt3_level == 2'h3) lv[1] = 1'b1;
      if (mlt3_level == 2'h2) lv[2] = 1'b1;
    end
    check({1'h0, lv}, 4'h3);
    rq.delete();
    fep_lp_i.go = 1;
    for (int k = 0; k < 2000 && fep_lp_i.go; k++) begin
      @(negedge clock);
      if (crs === 1'b1) seen = 1'b1;
    end
    cyc(200);
    check({3'h0, rq.size() >= 3}, 4'h1);
    check(rq[0], fep_pkg::NIB_PRE);
    check(rq[rq.size() - 2], 4'ha);
    check(rq[rq.size() - 1], 4'h3);
    @(negedge clock);
    check({3'h0, seen}, 4'h1);
    check({1'h0, rx_dv, crs, rx_er}, 4'h0);
    $display("test receive done");
  endtask : t_rx
  task t_sqe;
    int   n, hit, stb;
    logic busy;
    n = 0;
    hit = 0;
    stb = 0;
    busy = 1'b0;
    ctl(1'b0, 1'b0, 1'b0);
    check({2'h0, an_enabled, speed100}, 4'h0);
    @(posedge clock);
    mac_tx_en <= 1'b1;
    mac_txd <= 4'h5;
    // frame stays well below the jabber limit
    for (int k = 0; k < 400 && n < 8; k++) begin
      @(negedge clock);
      if (tx_nib_stb) n++;
    end
    check({3'h0, ten_tx_en}, 4'h1);
    @(posedge clock);
    mac_tx_en <= 1'b0;
    // pulse width, idle receive strobes and quiet carrier after the frame
    for (int k = 0; k < 400; k++) begin
      @(negedge clock);
      if (col === 1'b1) hit++;
      if (rx_nib_stb === 1'b1) stb++;
      if (crs !== 1'b0) busy = 1'b1;
    end
    check(hit, fep_pkg::SQE_LEN_CYC);
    check(stb, 400 / (4 * fep_pkg::BIT10_CYC));
    check({3'h0, busy}, 4'h0);
    $display("test sqe done");
  endtask : t_sqe
  task t_jab;
    cyc(100);
    mac_tx_en <= 1'b1;
    cyc(100);
    @(negedge clock);
    check({2'h0, col, ten_tx_en}, 4'h1);
    cyc(320);
    @(negedge clock);
    check({2'h0, col, ten_tx_en}, 4'h2);
    @(posedge clock);
    mac_tx_en <= 1'b0;
    cyc(150);
    @(negedge clock);
    check({3'h0, col}, 4'h1);
    cyc(110);
    @(negedge clock);
    check({3'h0, col}, 4'h0);
    $display("test jabber done");
  endtask : t_jab

  // main sequence
  initial begin
    cyc(4);
    rst <= 1'b0;
    cyc(4);
    t_reset();
    t_modes();
    t_pd();
    t_rx();
    t_sqe();
    t_jab();
    close_out();
  end
  // watchdog
  initial begin
    #500us;
    errors++;
    close_out();
  end
endmodule : fep_core_test

// ===== tb/fep_lp.sv
// cable link partner model: scrambled nrzi 100 mb/s stream on the receive pair
module fep_lp (
  // line toward the phy
  output logic line_rx
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [10:0] lfsr = 11'h7ff;
  bit          go   = 0;
  // one 5-bit symbol, msb first, one bit every 40 ns
  task send_sym(input logic [4:0] s);
    for (int i = 4; i >= 0; i--) begin
      lfsr = {lfsr[9:0], lfsr[10] ^ lfsr[8]};
      if (s[i] ^ lfsr[0]) line_rx = ~line_rx;
      #40;
    end
  endtask : send_sym
  // idle forever, one frame whenever go is set
  initial begin
    line_rx = 1'b0;
    #3;
    forever begin
      if (go) begin
        send_sym(fep_pkg::SYM_J);
        send_sym(fep_pkg::SYM_K);
        send_sym(fep_pkg::ENC[5]);
        send_sym(fep_pkg::ENC[13]);
        send_sym(fep_pkg::ENC[10]);
        send_sym(fep_pkg::ENC[3]);
        send_sym(fep_pkg::SYM_T);
        send_sym(fep_pkg::SYM_R);
        go = 0;
      end else begin
        send_sym(fep_pkg::SYM_I);
      end
    end
  end
endmodule : fep_lp
